// >>> verif/adcc_ana_model.sv
`default_nettype none

// Analog section stand-in: a value per channel while on, changing junk while off.
module adcc_ana_model (
    // Clock.
    input wire logic clk_i,
    // Controls from the block.
    input wire logic [2:0] mux_sel_i,
    input wire logic ana_on_i,
    // Converted value.
    output logic [9:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] last_q = 10'h000;

    // Track the last value so a switched-off section never holds it.
    always_ff @(posedge clk_i) begin
        last_q <= data_o;
    end

    // The channel sits in the top bits so each input gives its own value.
    always_comb begin
        data_o = ana_on_i ? {mux_sel_i, 7'h35} : ~last_q;
    end
endmodule

`default_nettype wire

// >>> verif/adcc_top_tb_top.sv
`default_nettype none

module adcc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adcc_pkg::*;
    logic clk = 0, rst_n = 0, ctrl_wr = 0, chan_wr = 0, flag_clr = 0, stop = 0;
    adcc_ctrl_t ctrl = '0, ctrl_o;
    logic [7:0] pins = 8'h00, pins_o;
    logic [2:0] chan = 3'h0, mux;
    logic [9:0] ana;
    logic [15:0] res;
    logic ana_on, done, irq, busy;
    int fail_count = 0, checks_done = 0, cyc;
    // Rows: control bits, channel, expected result.
    logic [24:0] rows [8] = '{{6'h24, 3'h0, 16'h0035}, {6'h25, 3'h7, 16'h6d40},
        {6'h20, 3'h2, 16'h004d}, {6'h32, 3'h6, 16'hcd00}, {6'h23, 3'h3, 16'hed00},
        {6'h24, 3'h1, 16'h00b5}, {6'h24, 3'h4, 16'h0235}, {6'h36, 3'h5, 16'had40}};

    adcc_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .CTRL_WR_I(ctrl_wr), .CTRL_I(ctrl),
        .PIN_ANALOG_EN_I(pins), .CHAN_WR_I(chan_wr), .CHAN_SEL_I(chan), .FLAG_CLR_I(flag_clr),
        .STOP_I(stop), .ANA_DATA_I(ana), .MUX_SEL_O(mux), .ANA_ON_O(ana_on),
        .PIN_ANALOG_O(pins_o), .CTRL_O(ctrl_o), .RESULT_O(res), .DONE_FLAG_O(done),
        .IRQ_O(irq), .BUSY_O(busy));
    adcc_ana_model ANA (.clk_i(clk), .mux_sel_i(mux), .ana_on_i(ana_on), .data_o(ana));

    // Clock of 50 ns period.
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Strobes last one cycle and are driven on the falling edge.
    task automatic wr_ctrl(input logic [5:0] c);
        @(negedge clk);
        ctrl_wr = 1;
        ctrl = adcc_ctrl_t'(c);
        @(negedge clk);
        ctrl_wr = 0;
    endtask

    task automatic start(input logic [2:0] ch);
        @(negedge clk);
        chan_wr = 1;
        chan = ch;
        @(negedge clk);
        chan_wr = 0;
    endtask

    task automatic clr_flag;
        @(negedge clk);
        flag_clr = 1;
        @(negedge clk);
        flag_clr = 0;
        @(negedge clk);
    endtask

    // Bounded wait; the figure is about 281 cycles after the start edge.
    task automatic wait_done(input logic [15:0] tag);
        cyc = 0;
        while (done !== 1'b1 && cyc < 400) begin
            @(negedge clk);
            cyc++;
        end
        chk({15'h0, cyc >= 275 && cyc <= 285}, 16'h1);
    endtask

    // A run needs about 4400 cycles; a hang is cut at 20000.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        chk(16'(ctrl_o), 16'h0);
        chk(ana_on, 0);
        start(3'h2);
        repeat (3) @(negedge clk);
        chk(busy, 0);
        chk(mux, 16'h2);
        foreach (rows[i]) begin
            pins = 8'h01 << rows[i][18:16];
            wr_ctrl(rows[i][24:19]);
            chk(pins_o, pins);
            chk(ana_on, 1);
            start(rows[i][18:16]);
            chk(busy, 1);
            chk(mux, rows[i][18:16]);
            wait_done(0);
            chk(res, rows[i][15:0]);
            @(negedge clk);
            chk(irq, rows[i][23]);
            chk(busy, 0);
        end
        clr_flag();
        chk({done, irq}, 0);
        // A second channel write restarts on the new input.
        start(3'h0);
        repeat (100) @(negedge clk);
        start(3'h5);
        wait_done(0);
        // Power-down in mid-conversion loses it and keeps the old result.
        start(3'h1);
        repeat (100) @(negedge clk);
        wr_ctrl(6'h16);
        @(negedge clk);
        chk({busy, ana_on}, 0);
        repeat (300) @(negedge clk);
        chk(done, 0);
        chk(res, 16'had40);
        wr_ctrl(6'h36);
        start(3'h2);
        repeat (100) @(negedge clk);
        stop = 1;
        repeat (2) @(negedge clk);
        chk({busy, ana_on}, 0);
        repeat (300) @(negedge clk);
        chk(done, 0);
        stop = 0;
        repeat (2) @(negedge clk);
        chk({ana_on, busy}, 16'h2);
        chk({16'(ctrl_o) | res}, 16'had76);
        wr_ctrl(6'h16);
        stop = 1;
        repeat (3) @(negedge clk);
        stop = 0;
        repeat (2) @(negedge clk);
        chk(ana_on, 0);
        wr_ctrl(6'h2c);
        start(3'h4);
        wait_done(0);
        chk(res, 16'h0235);
        chk(busy, 1);
        clr_flag();
        wait_done(0);
        // A clear that meets the next continuous completion loses to it.
        repeat (279) @(negedge clk);
        flag_clr = 1;
        @(negedge clk);
        flag_clr = 0;
        chk(done, 1);
        end_sim();
    end
endmodule

`default_nettype wire

// >>> verilog/adcc_conv_clk.sv
`default_nettype none

// Converter clock enable: one pulse every CONV_DIV system clocks.
module adcc_conv_clk
    import adcc_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Control.
    input wire logic en_i,
    input wire logic clr_i,
    // Converter clock enable pulse.
    output logic tick_o
);

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic tick_d;

    // Disabling the divider holds it at zero, so no converter clock runs in power-down.
    always_comb begin
        div_d = div_q;
        tick_d = 1'b0;
        if (!en_i || clr_i) begin
            div_d = '0;
        end else if (div_q == DIV_LAST) begin
            div_d = '0;
            tick_d = 1'b1;
        end else begin
            div_d = div_q + DIV_W'(1);
        end
    end

    // Divider register.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            div_q <= '0;
            tick_o <= 1'b0;
        end else begin
            div_q <= div_d;
            tick_o <= tick_d;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/adcc_pkg.sv
`default_nettype none

package adcc_pkg;

    // System clock and converter clock rates in hertz.
    localparam int CLK_HZ = 20_000_000;
    localparam int CONV_HZ = 2_000_000;

    // One conversion lasts this long at the converter clock rate.
    localparam int CONV_TIME_NS = 14000;

    // Derived cycle counts.
    localparam int CONV_DIV = CLK_HZ / CONV_HZ;
    localparam int CONV_TICKS = (CONV_TIME_NS * (CONV_HZ / 1_000_000)) / 1000;

    // Counter widths and terminal values.
    localparam int DIV_W = 4;
    localparam int CNT_W = 5;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_TICKS - 1);

    // Data widths.
    localparam int CHAN_W = 3;
    localparam int NUM_PINS = 8;
    localparam int RAW_W = 10;
    localparam int RES_W = 16;

    // Reset value of the control bits: powered down, everything off.
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Software control bits of the converter.
    typedef struct packed {
        logic power_up;
        logic int_en;
        logic cont;
        logic res10;
        logic left;
        logic sgn;
    } adcc_ctrl_t;

    // Sequencer states, Gray coded along off, idle, converting.
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_IDLE = 2'b01,
        ST_CONV = 2'b11
    } adcc_state_e_t;

    // Complete state of the control block.
    typedef struct packed {
        adcc_ctrl_t ctrl;
        logic [NUM_PINS-1:0] pins;
        logic [CHAN_W-1:0] mux;
        adcc_state_e_t state;
        logic [CNT_W-1:0] cnt;
        logic [RAW_W-1:0] ana_s1;
        logic [RAW_W-1:0] ana_s2;
        logic [RES_W-1:0] result;
        logic flag;
        logic done;
        logic irq;
        logic busy;
        logic ana_on;
    } adcc_st_t;

endpackage

`default_nettype wire

// >>> verilog/adcc_top.sv
`default_nettype none

// Summary of operation
// - Conversion takes twenty-eight converter clock periods.
// - Left-aligned signed result format is selectable.
// - Completion sets flag; interrupt when enabled.
// - Software selects one of eight inputs.
// - One-shot or continuous conversion sequencing.
// - Each pin selectable as port or analog.
// - Stop halts analog section, aborts conversion.
// - After stop, no auto start; registers kept.
// - Resume after stop only if powered up.
// - Clearing power-up gates clock, analog off.
// - Power-down aborts the running conversion.
// - Setting power-up returns to normal operation.
// - Control writes accepted while powered down.
// - Power-up bit resets to zero.
module adcc_top (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Control register write.
    input wire logic CTRL_WR_I,
    input wire adcc_pkg::adcc_ctrl_t CTRL_I,
    input wire logic [adcc_pkg::NUM_PINS-1:0] PIN_ANALOG_EN_I,
    // Channel select write, which also starts a conversion when powered.
    input wire logic CHAN_WR_I,
    input wire logic [adcc_pkg::CHAN_W-1:0] CHAN_SEL_I,
    // Completion flag clear and processor stop mode.
    input wire logic FLAG_CLR_I,
    input wire logic STOP_I,
    // Converted value from the analog section.
    input wire logic [adcc_pkg::RAW_W-1:0] ANA_DATA_I,
    // Analog side controls.
    output logic [adcc_pkg::CHAN_W-1:0] MUX_SEL_O,
    output logic ANA_ON_O,
    output logic [adcc_pkg::NUM_PINS-1:0] PIN_ANALOG_O,
    // Status and result.
    output adcc_pkg::adcc_ctrl_t CTRL_O,
    output logic [adcc_pkg::RES_W-1:0] RESULT_O,
    output logic DONE_FLAG_O,
    output logic IRQ_O,
    output logic BUSY_O
);
    import adcc_pkg::*;

    adcc_st_t st_q;
    adcc_st_t st_d;
    logic conv_tick;
    logic powered;
    logic start;
    logic finish;

    // Result formatting by resolution, alignment and sign.
    function automatic logic [RES_W-1:0] fmt_result(input logic [RAW_W-1:0] raw, input adcc_ctrl_t c);
        logic [7:0] raw8;
        logic [RES_W-1:0] r;
        raw8 = raw[RAW_W-1:2];
        if (c.res10) begin
            if (c.sgn) begin
                r = {~raw[9], raw[8:0], 6'h00};
            end else if (c.left) begin
                r = {raw, 6'h00};
            end else begin
                r = {6'h00, raw};
            end
        end else begin
            if (c.sgn) begin
                r = {~raw8[7], raw8[6:0], 8'h00};
            end else if (c.left) begin
                r = {raw8, 8'h00};
            end else begin
                r = {8'h00, raw8};
            end
        end
        return r;
    endfunction

    // Power follows the power-up bit being written this cycle, else the stored one; stop overrides it.
    // Taking the bit from the write data rather than the next state keeps the decode free of loops.
    assign powered = (CTRL_WR_I ? CTRL_I.power_up : st_q.ctrl.power_up) && !STOP_I;
    assign start = CHAN_WR_I && powered;
    // The last converter period of a conversion that still has power.
    assign finish = (st_q.state == ST_CONV) && conv_tick && powered && (st_q.cnt == CNT_LAST);

    // The divider is cleared on a start so every conversion sees full converter periods.
    adcc_conv_clk u_conv_clk (
        .CLK_I(CLK_I),
        .RST_N_I(RST_N_I),
        .en_i(st_q.ana_on),
        .clr_i(start),
        .tick_o(conv_tick)
    );

    // Next state of the whole block.
    always_comb begin
        st_d = st_q;
        st_d.ana_s1 = ANA_DATA_I;
        st_d.ana_s2 = st_q.ana_s1;
        st_d.done = 1'b0;
        // Writes are serviced whatever the power state.
        if (CTRL_WR_I) begin
            st_d.ctrl = CTRL_I;
            st_d.pins = PIN_ANALOG_EN_I;
        end
        if (FLAG_CLR_I || CHAN_WR_I) begin
            st_d.flag = 1'b0;
        end
        if (CHAN_WR_I) begin
            st_d.mux = CHAN_SEL_I;
        end
        unique case (st_q.state)
            ST_OFF: begin
                if (powered) begin
                    st_d.state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                st_d.state = ST_IDLE;
            end
            ST_CONV: begin
                // A tick that meets a power loss is dropped, so an aborted run never posts a result.
                if (finish) begin
                    st_d.result = fmt_result(st_q.ana_s2, st_q.ctrl);
                    st_d.flag = 1'b1;
                    st_d.done = 1'b1;
                    st_d.cnt = '0;
                    if (!st_q.ctrl.cont) begin
                        st_d.state = ST_IDLE;
                    end
                end else if (conv_tick && powered) begin
                    st_d.cnt = st_q.cnt + CNT_W'(1);
                end
            end
            default: begin
                st_d.state = ST_OFF;
            end
        endcase
        // A channel write restarts, abandoning any conversion underway.
        if (start) begin
            st_d.state = ST_CONV;
            st_d.cnt = '0;
        end
        // Stop or power-down drops the conversion; a later return stays idle.
        if (!powered) begin
            st_d.state = ST_OFF;
            st_d.cnt = '0;
        end
        st_d.ana_on = powered;
        st_d.busy = (st_d.state == ST_CONV);
        st_d.irq = st_d.flag && st_d.ctrl.int_en;
    end

    // State register; the control bits clear, so the block wakes powered down.
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q <= '0;
            st_q.ctrl <= CTRL_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register.
    assign MUX_SEL_O = st_q.mux;
    assign ANA_ON_O = st_q.ana_on;
    assign PIN_ANALOG_O = st_q.pins;
    assign CTRL_O = st_q.ctrl;
    assign RESULT_O = st_q.result;
    assign DONE_FLAG_O = st_q.flag;
    assign IRQ_O = st_q.irq;
    assign BUSY_O = st_q.busy;

    // Checks on the running design.
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // Each check names the rule it guards on its label line.
    // Checks on the result format look at the settings of the completing cycle,
    // because a control write in that very cycle only takes effect afterwards.

    // A conversion ends on its twenty-eighth converter period.
    a_conv_length: assert property (finish && !start
        |=> DONE_FLAG_O && (st_q.cnt == 5'h00)) else $error("conversion did not end after 28 periods");
    // Left alone, the converter clock returns exactly ten system clocks later.
    // A restart or a power loss inside the gap makes the pattern void.
    a_tick_spacing: assert property (conv_tick && st_q.ana_on && !start ##1 (st_q.ana_on && !start) [*8]
        ##1 (st_q.ana_on && !start) |=> conv_tick) else $error("converter clock period wrong");
    // Restarts and power loss may only lengthen the gap between ticks.
    a_tick_gap: assert property (conv_tick
        |=> !conv_tick [*8] ##1 !conv_tick) else $error("converter clock came early");
    // The step counter advances once per tick.
    a_cnt_step: assert property ((st_q.state == ST_CONV) && conv_tick && powered && !start
        && (st_q.cnt != CNT_LAST) |=> st_q.cnt == $past(st_q.cnt) + 5'h01) else $error("step count stuck");
    // Between ticks the step count holds and the conversion keeps running.
    a_cnt_hold: assert property ((st_q.state == ST_CONV) && !conv_tick && powered && !start
        |=> $stable(st_q.cnt) && BUSY_O) else $error("step count moved without a tick");
    // Signed 10-bit results carry the inverted top data bit.
    a_signed_fmt: assert property (st_q.done && $past(st_q.ctrl.sgn) && $past(st_q.ctrl.res10)
        |-> RESULT_O[15] == ~$past(st_q.ana_s2[9])) else $error("signed result sign bit wrong");
    // Left-aligned and signed 10-bit results leave the six low bits clear.
    a_left_fmt: assert property (st_q.done && $past(st_q.ctrl.res10)
        && ($past(st_q.ctrl.left) || $past(st_q.ctrl.sgn)) |-> RESULT_O[5:0] == 6'h00) else $error("left result low bits set");
    // A right-aligned 10-bit result is the sampled value itself.
    a_right_data: assert property (st_q.done && $past(st_q.ctrl.res10) && !$past(st_q.ctrl.left)
        && !$past(st_q.ctrl.sgn) |-> RESULT_O == {6'h00, $past(st_q.ana_s2)}) else $error("right result wrong");
    // A right-aligned 8-bit result leaves the upper byte clear.
    a_narrow_right: assert property (st_q.done && !$past(st_q.ctrl.res10) && !$past(st_q.ctrl.left)
        && !$past(st_q.ctrl.sgn) |-> RESULT_O[15:8] == 8'h00) else $error("narrow right result wrong");
    // A left-aligned or signed 8-bit result leaves the lower byte clear.
    a_narrow_left: assert property (st_q.done && !$past(st_q.ctrl.res10)
        && ($past(st_q.ctrl.left) || $past(st_q.ctrl.sgn)) |-> RESULT_O[7:0] == 8'h00) else $error("narrow left result wrong");
    // The interrupt stands while the flag and its enable do.
    a_irq_follow: assert property (DONE_FLAG_O && CTRL_O.int_en |-> IRQ_O) else $error("interrupt missing");
    // No interrupt without both the flag and its enable.
    a_irq_masked: assert property (!(DONE_FLAG_O && CTRL_O.int_en)
        |-> !IRQ_O) else $error("interrupt without cause");
    // Every completion leaves the flag set.
    a_done_flag: assert property (st_q.done
        |-> DONE_FLAG_O) else $error("completion left flag clear");
    // A completion wins over a clear in the same cycle.
    a_flag_wins: assert property (finish && (FLAG_CLR_I || CHAN_WR_I)
        |=> DONE_FLAG_O) else $error("clear beat completion");
    // A clear with no completion drops the flag.
    a_flag_clear: assert property ((FLAG_CLR_I || CHAN_WR_I) && !finish
        |=> !DONE_FLAG_O) else $error("flag not cleared");
    // Otherwise the flag holds, power state notwithstanding.
    a_flag_hold: assert property (!FLAG_CLR_I && !CHAN_WR_I && !finish
        |=> $stable(DONE_FLAG_O)) else $error("flag changed alone");
    // A channel write reaches the multiplexer on the next cycle.
    a_mux_select: assert property (CHAN_WR_I |=> MUX_SEL_O == $past(CHAN_SEL_I)) else $error("mux not updated");
    // The multiplexer moves only on a channel write.
    a_mux_hold: assert property (!CHAN_WR_I
        |=> $stable(MUX_SEL_O)) else $error("mux moved alone");
    // A one-shot conversion stops after its result.
    a_one_shot: assert property (st_q.done && !$past(st_q.ctrl.cont) && !$past(start)
        |-> !BUSY_O) else $error("one-shot kept running");
    // Continuous mode starts the next conversion from step zero.
    a_cont_restart: assert property (finish && st_q.ctrl.cont
        |=> BUSY_O && (st_q.cnt == 5'h00)) else $error("continuous mode did not restart");
    // Pin configuration follows a control write.
    a_pin_cfg: assert property (CTRL_WR_I |=> PIN_ANALOG_O == $past(PIN_ANALOG_EN_I)) else $error("pin config lost");
    // Pin configuration moves only on a control write.
    a_pin_hold: assert property (!CTRL_WR_I
        |=> $stable(PIN_ANALOG_O)) else $error("pin config moved alone");
    // Stop turns the analog section off and drops the conversion.
    a_stop_abort: assert property (STOP_I |=> !ANA_ON_O && !BUSY_O) else $error("stop did not abort");
    // Without power the sequencer sits in its off state.
    a_off_state: assert property (!powered
        |=> st_q.state == ST_OFF) else $error("sequencer not off");
    // Stop leaves the control bits alone.
    a_stop_hold: assert property (STOP_I && !CTRL_WR_I |=> $stable(CTRL_O)) else $error("stop changed control");
    // Leaving stop starts nothing by itself.
    a_stop_exit: assert property ($fell(STOP_I) && !CHAN_WR_I |-> ##1 !BUSY_O) else $error("conversion began alone");
    // An idle sequencer waits for a channel write.
    a_idle_stays: assert property ((st_q.state == ST_IDLE) && !start
        |=> !BUSY_O) else $error("idle sequencer started alone");
    // Power returns after stop when the power-up bit is set.
    a_wake_up: assert property (!STOP_I && CTRL_O.power_up && !CTRL_WR_I
        |=> ANA_ON_O) else $error("no return from low power");
    // A cleared power-up bit turns the section and its clock off.
    a_power_down: assert property (!CTRL_O.power_up && !CTRL_WR_I
        |=> !ANA_ON_O && !BUSY_O ##1 !conv_tick) else $error("power-down incomplete");
    // A channel write without power starts nothing.
    a_pd_refuse: assert property (CHAN_WR_I && !powered
        |=> !BUSY_O) else $error("conversion started without power");
    // The converter clock stays still while the section is off.
    a_no_tick_off: assert property (!st_q.ana_on
        |=> !conv_tick) else $error("converter clock ran while off");
    // The result moves only on a completion, so aborted runs keep the old one.
    a_result_hold: assert property (!st_q.done
        |-> $stable(RESULT_O)) else $error("result changed without completion");
    // The sequencer leaves its off state as soon as power returns.
    a_off_wake: assert property ((st_q.state == ST_OFF) && powered && !start
        |=> st_q.state == ST_IDLE) else $error("sequencer stayed off");
    // The analog section follows the power decision.
    a_ana_follow: assert property (powered
        |=> ANA_ON_O) else $error("analog section not on");
    // Control writes land in any power state.
    a_ctrl_load: assert property (CTRL_WR_I
        |=> CTRL_O == $past(CTRL_I)) else $error("control write lost");
    // A powered channel write starts afresh; a completion in that cycle still sets the flag.
    a_start_conv: assert property (CHAN_WR_I && CTRL_O.power_up && !CTRL_WR_I && !STOP_I && !finish
        |=> BUSY_O && st_q.cnt == 5'h00 && !DONE_FLAG_O) else $error("channel write did not start");

endmodule

`default_nettype wire
